// ==== design/safety_eval_pkg.sv ====
// Shared constants and types for the safety input evaluator.
// Assumes a single 25 MHz clock and a one-millisecond time base derived from it.
package safety_eval_pkg;

  // Clock rate and the millisecond tick derived from it.
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_CNT_W = 15;

  // Evaluator numbering: grip, testable pair, solid-state pair.
  localparam int NUM_EVAL = 3;
  localparam int EV_GRIP = 0;
  localparam int EV_TEST = 1;
  localparam int EV_SOLID = 2;

  // Positions of the contact and reset inputs in the filtered vector.
  localparam int NUM_IN = 10;
  localparam int G_A = 0;
  localparam int G_B = 1;
  localparam int G_C = 2;
  localparam int G_R = 3;
  localparam int T_A = 4;
  localparam int T_B = 5;
  localparam int T_R = 6;
  localparam int S_A = 7;
  localparam int S_B = 8;
  localparam int S_R = 9;
  localparam int RST_IDX [NUM_EVAL] = '{G_R, T_R, S_R};
  localparam int IN_EV [NUM_IN] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2};

  // Bounce filter limits in milliseconds.
  localparam logic [7:0] FILT_MIN_MS = 8'h03;
  localparam logic [7:0] FILT_MAX_MS = 8'hfa;

  // Virtual input image widths for the two variants.
  localparam int NUM_VIRT_EXT = 32;
  localparam int NUM_VIRT_BASIC = 8;

  // Values after reset.
  localparam logic OUT_RST = 1'b0;
  localparam logic CONST_HIGH_RST = 1'b1;
  localparam logic [7:0] SIM_CNT_RST = 8'h00;

  // Restart behaviour after the safe output drops.
  typedef enum logic [1:0] {RST_NONE, RST_MANUAL, RST_MONITORED} reset_mode_t;

  // Sequencing states of one evaluator.
  typedef enum logic [1:0] {ST_POT, ST_LOCK, ST_ARMED, ST_RUN} eval_state_t;

  // Configuration of one evaluator.
  typedef struct packed {
    reset_mode_t reset_mode;
    logic pot_en;
    logic err_en;
    logic [7:0] filter_ms;
    logic [7:0] sim_ms;
    logic sim_en;
    logic antivalent;
  } eval_cfg_t;

  // Sensor anomalies reported by the speed monitor.
  typedef struct packed {
    logic no_sensor;
    logic no_wiring;
    logic no_supply;
    logic freq_mismatch;
    logic phase_duty;
  } speed_fault_t;

endpackage

// ==== design/contact_filter.sv ====
// Bounce filter for one synchronised contact input.
// Assumes raw_i is already in the clk_i domain and tick_i pulses once per millisecond.
`timescale 1ns/100ps
module contact_filter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic [7:0] len_ms_i,
  output logic level_o
);
  import safety_eval_pkg::*;

  logic [7:0] eff_len; // Filter length clamped into the legal range.
  logic [7:0] cnt_ff; // Milliseconds the new level has been stable.
  logic level_ff; // Accepted level.

  // Clamp the configured length so a bad setting cannot disable the filter.
  always_comb begin
    if (len_ms_i < FILT_MIN_MS) begin
      eff_len = FILT_MIN_MS;
    end else if (len_ms_i > FILT_MAX_MS) begin
      eff_len = FILT_MAX_MS;
    end else begin
      eff_len = len_ms_i;
    end
  end

  // Accept a new level only after it held for the full length; any bounce restarts.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= SIM_CNT_RST;
      level_ff <= OUT_RST;
    end else if (raw_i == level_ff) begin
      cnt_ff <= SIM_CNT_RST;
    end else if (tick_i) begin
      if (cnt_ff + 8'h01 >= eff_len) begin
        level_ff <= raw_i;
        cnt_ff <= SIM_CNT_RST;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign level_o = level_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_filter_on_tick: assert property ($changed(level_ff) |-> $past(tick_i))
    else $error("Filtered level changed without a millisecond tick.");
  a_filter_len_met: assert property ($changed(level_ff) |-> $past(cnt_ff) + 8'h01 >= $past(eff_len))
    else $error("Filtered level changed before the filter length elapsed.");
  c_filter_change: cover property ($rose(level_ff));

endmodule // contact_filter

// ==== design/safety_input_evaluator.sv ====
// Safety input evaluator: grip, testable pair and solid-state pair evaluators,
// speed fault flag, virtual fieldbus inputs and constant level sources.
// Assumes contact, reset and speed fault pins are asynchronous to clk_i;
// the fieldbus image and configuration come from logic on clk_i.
`timescale 1ns/100ps
module safety_input_evaluator #(
  parameter int MS_CYCLES_P = safety_eval_pkg::MS_CYCLES // Clock cycles per millisecond.
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] first_contact_input_i,
  input wire logic [2:0] second_contact_input_i,
  input wire logic third_contact_input_i,
  input wire logic [2:0] reset_input_i,
  input wire safety_eval_pkg::eval_cfg_t [2:0] cfg_i,
  input wire safety_eval_pkg::speed_fault_t speed_fault_i,
  input wire logic speed_err_en_i,
  input wire logic [31:0] fieldbus_image_i,
  input wire logic extended_variant_i,
  output logic [2:0] safe_out_o,
  output logic [2:0] error_out_o,
  output logic speed_err_o,
  output logic [31:0] virtual_in_o,
  output logic constant_low_source_o,
  output logic constant_high_source_o
);
  import safety_eval_pkg::*;

  logic [NUM_IN-1:0] raw_w; // Pin inputs in filter order.
  logic [NUM_IN-1:0] sync1_ff; // First synchroniser stage.
  logic [NUM_IN-1:0] sync2_ff; // Second synchroniser stage.
  logic [NUM_IN-1:0] flt; // Debounced levels.
  speed_fault_t spd1_ff; // First synchroniser stage of the speed faults.
  speed_fault_t spd2_ff; // Second synchroniser stage of the speed faults.
  logic [TICK_CNT_W-1:0] tick_cnt_ff; // Divider for the millisecond tick.
  logic tick_ff; // One-cycle millisecond pulse.
  logic [2:0] ok_w; // Contacts show the safe (run) pattern.
  logic [2:0] idle_w; // Contacts show the released (idle) pattern of their evaluator type.
  logic [2:0] differ_w; // Contact pair breaks its equivalent or antivalent relation, so a switching is under way.
  logic [2:0] sim_on_w; // Simultaneity check is active.
  logic [2:0] safe_ff; // Registered safe outputs.
  logic [2:0] err_ff; // Registered error outputs.
  logic [2:0] sim_err_ff; // Latched simultaneity errors.
  logic speed_err_ff; // Registered speed error bit.
  logic [31:0] virt_ff; // Registered virtual inputs.
  logic const_low_ff; // Constant low source.
  logic const_high_ff; // Constant high source.

  // Collect the pins in filter order; each reset input follows its contacts.
  assign raw_w = {reset_input_i[2], second_contact_input_i[2], first_contact_input_i[2],
                  reset_input_i[1], second_contact_input_i[1], first_contact_input_i[1],
                  reset_input_i[0], third_contact_input_i, second_contact_input_i[0],
                  first_contact_input_i[0]};

  // Two-stage synchronisers for all asynchronous pins.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      spd1_ff <= '0;
      spd2_ff <= '0;
    end else begin
      sync1_ff <= raw_w;
      sync2_ff <= sync1_ff;
      spd1_ff <= speed_fault_i;
      spd2_ff <= spd1_ff;
    end
  end

  // Millisecond time base for the filters and the simultaneity timers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_CNT_W'(MS_CYCLES_P - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // One bounce filter per input, timed by its evaluator's setting.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
      contact_filter u_filt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick_ff),
        .raw_i(sync2_ff[gi]),
        .len_ms_i(cfg_i[IN_EV[gi]].filter_ms),
        .level_o(flt[gi])
      );
    end
  endgenerate

  // Contact pattern decoding for each evaluator type.
  always_comb begin
    // Grip: middle position only when all three contacts are closed.
    ok_w[EV_GRIP] = flt[G_A] && flt[G_B] && flt[G_C];
    idle_w[EV_GRIP] = !flt[G_A] && !flt[G_B] && flt[G_C];
    differ_w[EV_GRIP] = flt[G_A] ^ flt[G_B];
    sim_on_w[EV_GRIP] = 1'b1;
    // Testable pair: equivalent or antivalent contacts.
    if (cfg_i[EV_TEST].antivalent) begin
      ok_w[EV_TEST] = flt[T_A] && !flt[T_B];
      idle_w[EV_TEST] = !flt[T_A] && flt[T_B];
      differ_w[EV_TEST] = !(flt[T_A] ^ flt[T_B]);
    end else begin
      ok_w[EV_TEST] = flt[T_A] && flt[T_B];
      idle_w[EV_TEST] = !flt[T_A] && !flt[T_B];
      differ_w[EV_TEST] = flt[T_A] ^ flt[T_B];
    end
    sim_on_w[EV_TEST] = cfg_i[EV_TEST].sim_en;
    // Solid-state pair: both inputs at the active level.
    ok_w[EV_SOLID] = flt[S_A] && flt[S_B];
    idle_w[EV_SOLID] = !flt[S_A] && !flt[S_B];
    differ_w[EV_SOLID] = flt[S_A] ^ flt[S_B];
    sim_on_w[EV_SOLID] = 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Sequencing shared by all evaluators: power-on test, restart, simultaneity.
  genvar ge;
  generate
    for (ge = 0; ge < NUM_EVAL; ge++) begin : g_eval
      logic rst_prev_ff; // Reset input level one cycle ago.
      logic rst_rise; // Rising edge of the filtered reset input.
      logic rst_fall; // Falling edge of the filtered reset input.
      logic pot_ok_ff; // Power-on test has seen the device in its run pattern.
      logic [7:0] sim_cnt_ff; // Milliseconds the contacts have disagreed.
      eval_state_t st_ff; // Sequencing state.
      eval_state_t nxt_st; // Next sequencing state.

      assign rst_rise = flt[RST_IDX[ge]] && !rst_prev_ff;
      assign rst_fall = !flt[RST_IDX[ge]] && rst_prev_ff;

      // Remember the reset input to find its edges, and note a real activation seen
      // during the power-on test, since the filters leave reset with every contact low.
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          rst_prev_ff <= 1'b0;
          pot_ok_ff <= 1'b0;
        end else begin
          rst_prev_ff <= flt[RST_IDX[ge]];
          pot_ok_ff <= pot_ok_ff || (st_ff == ST_POT && ok_w[ge]);
        end
      end

      // Time the contact skew; the error is held until all contacts are idle.
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          sim_cnt_ff <= SIM_CNT_RST;
          sim_err_ff[ge] <= 1'b0;
        end else begin
          if (!differ_w[ge]) begin
            sim_cnt_ff <= SIM_CNT_RST;
          end else if (tick_ff && sim_cnt_ff != 8'hff) begin
            sim_cnt_ff <= sim_cnt_ff + 8'h01;
          end
          // A new error wins over the idle clear in the same cycle.
          if (sim_on_w[ge] && differ_w[ge] && tick_ff && sim_cnt_ff >= cfg_i[ge].sim_ms) begin
            sim_err_ff[ge] <= 1'b1;
          end else if (idle_w[ge]) begin
            sim_err_ff[ge] <= 1'b0;
          end
        end
      end

      // Next state: restart handling after power-up and after each trip.
      always_comb begin
        nxt_st = st_ff;
        case (st_ff)
          // Power-on test waits for the device to be activated, then cleared.
          ST_POT: begin
            if (idle_w[ge] && pot_ok_ff) begin
              nxt_st = ST_LOCK;
            end
          end
          // Output locked until the restart condition is met.
          ST_LOCK: begin
            if (ok_w[ge] && !sim_err_ff[ge]) begin
              case (cfg_i[ge].reset_mode)
                RST_NONE: nxt_st = ST_RUN;
                RST_MANUAL: nxt_st = rst_rise ? ST_RUN : ST_LOCK;
                RST_MONITORED: nxt_st = rst_rise ? ST_ARMED : ST_LOCK;
                default: nxt_st = ST_LOCK;
              endcase
            end
          end
          // Monitored reset seen rising; wait for its return to low.
          ST_ARMED: begin
            if (!ok_w[ge] || sim_err_ff[ge]) begin
              nxt_st = ST_LOCK;
            end else if (rst_fall) begin
              nxt_st = ST_RUN;
            end
          end
          // Running: any trip demands a new reset when reset is enabled.
          ST_RUN: begin
            if (!ok_w[ge] && cfg_i[ge].reset_mode != RST_NONE) begin
              nxt_st = ST_LOCK;
            end
          end
          default: nxt_st = ST_LOCK;
        endcase
      end

      // State register; the power-on test is chosen at the end of reset.
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          st_ff <= ST_POT;
        end else if (st_ff == ST_POT && !cfg_i[ge].pot_en) begin
          st_ff <= ST_LOCK;
        end else begin
          st_ff <= nxt_st;
        end
      end

      // Safe output and error output, both registered.
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          safe_ff[ge] <= OUT_RST;
          err_ff[ge] <= OUT_RST;
        end else begin
          safe_ff[ge] <= (st_ff == ST_RUN) && ok_w[ge] && !sim_err_ff[ge];
          err_ff[ge] <= cfg_i[ge].err_en && sim_err_ff[ge];
        end
      end

      a_sim_flag_set: assert property (sim_on_w[ge] && differ_w[ge] && tick_ff
          && sim_cnt_ff >= cfg_i[ge].sim_ms |=> sim_err_ff[ge])
        else $error("Simultaneity error not flagged after limit.");
      a_sim_err_hold: assert property (sim_err_ff[ge] && !idle_w[ge] |=> sim_err_ff[ge])
        else $error("Simultaneity error cleared before contacts went idle.");
      a_sim_out_low: assert property (sim_err_ff[ge] |=> !safe_out_o[ge])
        else $error("Safe output high during simultaneity error.");
      a_manual_needs_edge: assert property (st_ff == ST_LOCK
          && cfg_i[ge].reset_mode == RST_MANUAL && !rst_rise |=> st_ff != ST_RUN)
        else $error("Manual reset released without a rising edge.");
      a_monitor_two_edges: assert property (st_ff == ST_LOCK
          && cfg_i[ge].reset_mode == RST_MONITORED |=> st_ff != ST_RUN)
        else $error("Monitored reset released without a falling edge.");
      a_trip_relock: assert property (st_ff == ST_RUN && !ok_w[ge]
          && cfg_i[ge].reset_mode != RST_NONE |=> st_ff == ST_LOCK ##1 !safe_out_o[ge])
        else $error("Trip did not demand a new reset.");
      a_pot_holds_low: assert property (st_ff == ST_POT |=> !safe_out_o[ge] ##1 !safe_out_o[ge])
        else $error("Safe output high before the power-on test.");
      a_err_out_match: assert property (##1 error_out_o[ge]
          == $past(cfg_i[ge].err_en && sim_err_ff[ge]))
        else $error("Error output does not report the fault.");
      c_monitored_run: cover property (st_ff == ST_ARMED ##1 st_ff == ST_RUN);
      c_sim_error: cover property ($rose(sim_err_ff[ge]));
    end
  endgenerate

  // Speed monitor faults only raise the error bit; no safe output is touched.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      speed_err_ff <= OUT_RST;
    end else begin
      speed_err_ff <= speed_err_en_i && (|spd2_ff);
    end
  end

  // Virtual inputs: full image in the extended variant, low byte otherwise.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      virt_ff <= '0;
    end else if (extended_variant_i) begin
      virt_ff <= fieldbus_image_i;
    end else begin
      virt_ff <= {{(NUM_VIRT_EXT - NUM_VIRT_BASIC){1'b0}},
                  fieldbus_image_i[NUM_VIRT_BASIC-1:0]};
    end
  end

  // Constant level sources, fixed from reset onward.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      const_low_ff <= OUT_RST;
      const_high_ff <= CONST_HIGH_RST;
    end else begin
      const_low_ff <= 1'b0;
      const_high_ff <= 1'b1;
    end
  end

  assign safe_out_o = safe_ff;
  assign error_out_o = err_ff;
  assign speed_err_o = speed_err_ff;
  assign virtual_in_o = virt_ff;
  assign constant_low_source_o = const_low_ff;
  assign constant_high_source_o = const_high_ff;

  a_grip_middle: assert property (safe_out_o[EV_GRIP] |-> $past(flt[G_C:G_A] == 3'b111))
    else $error("Grip output high outside the middle position.");
  a_equiv_pair: assert property (safe_out_o[EV_TEST] && !$past(cfg_i[EV_TEST].antivalent)
      |-> $past(flt[T_B:T_A] == 2'b11))
    else $error("Equivalent pair output high without both contacts.");
  a_anti_pair: assert property (safe_out_o[EV_TEST] && $past(cfg_i[EV_TEST].antivalent)
      |-> $past(flt[T_B:T_A] == 2'b01))
    else $error("Antivalent pair output high with wrong contacts.");
  a_test_sim_off: assert property (!cfg_i[EV_TEST].sim_en && !sim_err_ff[EV_TEST]
      |=> !sim_err_ff[EV_TEST])
    else $error("Testable pair flagged skew with checking disabled.");
  a_solid_out: assert property (safe_out_o[EV_SOLID] |-> $past(flt[S_A] && flt[S_B]))
    else $error("Solid-state output high with an input low.");
  a_speed_err: assert property (speed_err_en_i && (|spd2_ff) |=> speed_err_o)
    else $error("Speed anomaly not reported on the error bit.");
  a_basic_image: assert property (!extended_variant_i |=> virtual_in_o[31:8] == 24'h0)
    else $error("Basic variant drives bits above the first byte.");
  a_const_levels: assert property (##1 !constant_low_source_o && constant_high_source_o)
    else $error("Constant sources do not hold their levels.");
  c_grip_run: cover property ($rose(safe_out_o[EV_GRIP]));
  c_solid_run: cover property ($rose(safe_out_o[EV_SOLID]));

endmodule // safety_input_evaluator

// ==== tb/safety_field_model.sv ====
// Field wiring model: contacts, grip contacts and reset pushbuttons.
// Assumes the bench changes its commands on the falling clock edge.
`timescale 1ns/100ps
module safety_field_model (
  input wire logic clk_i,
  input wire logic bounce_i,
  input wire logic [2:0] first_cmd_i,
  input wire logic [2:0] second_cmd_i,
  input wire logic third_cmd_i,
  input wire logic [2:0] button_cmd_i,
  output logic [2:0] first_contact_input_o,
  output logic [2:0] second_contact_input_o,
  output logic third_contact_input_o,
  output logic [2:0] reset_input_o
);
  logic [1:0] phase_ff = 2'h0; // Edge count inside one chatter half period.
  logic chatter_ff = 1'b0; // Bounce pattern, flips every third edge.

  // Flip the chatter every three cycles, well inside one millisecond tick.
  always @(negedge clk_i) begin
    phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
    if (phase_ff == 2'h2) begin
      chatter_ff <= ~chatter_ff;
    end
  end

  // Each pushbutton sits on the pin right after its evaluator's contacts.
  assign reset_input_o = button_cmd_i;
  // Normally open contacts chatter while bounce is requested.
  assign first_contact_input_o = first_cmd_i ^ {3{bounce_i & chatter_ff}};
  assign second_contact_input_o = second_cmd_i ^ {3{bounce_i & chatter_ff}};
  assign third_contact_input_o = third_cmd_i;
endmodule // safety_field_model

// ==== tb/testbench.sv ====
// Self-checking bench for the safety input evaluator.
// Assumes a 4-cycle millisecond tick and a 3 ms filter, so one filter pass is 12 cycles.
`timescale 1ns/100ps
module testbench;
  import safety_eval_pkg::*;
  localparam int MS_P = 4; // Short millisecond so the run stays brief.
  typedef struct packed {
    logic [2:0] f;
    logic [2:0] s;
    logic t;
    logic av;
    logic [2:0] exp;
  } row_t;
  // Contact patterns beside the safe outputs they must give.
  row_t rows [9] = '{'{3'h7, 3'h7, 1'h1, 1'h0, 3'h7}, '{3'h0, 3'h0, 1'h1, 1'h0, 3'h0},
    '{3'h0, 3'h0, 1'h0, 1'h0, 3'h0}, '{3'h7, 3'h7, 1'h1, 1'h0, 3'h7},
    '{3'h3, 3'h5, 1'h1, 1'h0, 3'h1}, '{3'h7, 3'h5, 1'h1, 1'h1, 3'h7},
    '{3'h5, 3'h7, 1'h1, 1'h1, 3'h5}, '{3'h7, 3'h7, 1'h1, 1'h1, 3'h5},
    '{3'h0, 3'h0, 1'h1, 1'h1, 3'h0}};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic bounce = 1'b0;
  logic third_cmd = 1'b1;
  logic ext_var = 1'b1;
  logic speed_en = 1'b1;
  logic [2:0] first_cmd = 3'h0;
  logic [2:0] second_cmd = 3'h0;
  logic [2:0] button_cmd = 3'h0;
  logic [2:0] first_pin, second_pin, reset_pin, safe_out, err_out;
  logic third_pin, speed_err, const_lo, const_hi;
  eval_cfg_t [2:0] cfg;
  speed_fault_t fault = '0;
  logic [31:0] image = 32'h0;
  logic [31:0] virt;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  safety_field_model u_field (.clk_i(clk_i), .bounce_i(bounce), .first_cmd_i(first_cmd),
    .second_cmd_i(second_cmd), .third_cmd_i(third_cmd), .button_cmd_i(button_cmd),
    .first_contact_input_o(first_pin), .second_contact_input_o(second_pin),
    .third_contact_input_o(third_pin), .reset_input_o(reset_pin));

  safety_input_evaluator #(.MS_CYCLES_P(MS_P)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .first_contact_input_i(first_pin), .second_contact_input_i(second_pin),
    .third_contact_input_i(third_pin), .reset_input_i(reset_pin), .cfg_i(cfg),
    .speed_fault_i(fault), .speed_err_en_i(speed_en), .fieldbus_image_i(image),
    .extended_variant_i(ext_var), .safe_out_o(safe_out), .error_out_o(err_out),
    .speed_err_o(speed_err), .virtual_in_o(virt), .constant_low_source_o(const_lo),
    .constant_high_source_o(const_hi));

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one observed value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Lets n falling edges pass; inputs change right after.
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Sets one evaluator's options with a 3 ms filter and error output on.
  task automatic setc(input int i, input reset_mode_t m, input logic pot, input logic [7:0] sm,
    input logic se);
    cfg[i] = '{reset_mode: m, pot_en: pot, err_en: 1'b1, filter_ms: 8'h03, sim_ms: sm,
      sim_en: se, antivalent: 1'b0};
  endtask

  // Clock at 25 MHz.
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      results();
    end
  end

  // Main sequence: reset, table of patterns, then the awkward cases.
  initial begin
    setc(0, RST_NONE, 1'b0, 8'hff, 1'b0);
    setc(1, RST_NONE, 1'b0, 8'h02, 1'b0);
    setc(2, RST_NONE, 1'b0, 8'hff, 1'b0);
    step(8);
    chk(32'(safe_out), 32'h0);
    chk({30'h0, const_hi, const_lo}, 32'h2);
    rst_n_i = 1'b1;
    foreach (rows[k]) begin
      first_cmd = rows[k].f;
      second_cmd = rows[k].s;
      third_cmd = rows[k].t;
      cfg[1].antivalent = rows[k].av;
      step(30);
      chk(32'(safe_out), 32'(rows[k].exp));
      chk(32'(err_out), 32'h0);
    end
    // Virtual inputs in both variants.
    image = 32'h5ac3e96b;
    step(2);
    chk(virt, 32'h5ac3e96b);
    ext_var = 1'b0;
    step(2);
    chk(virt, 32'h0000006b);
    // Each speed anomaly raises the error bit but leaves the safe outputs alone.
    first_cmd = 3'h7;
    second_cmd = 3'h7;
    cfg[1].antivalent = 1'b0;
    step(30);
    for (int b = 0; b < 5; b++) begin
      fault = speed_fault_t'(5'h01 << b);
      step(5);
      chk(32'(speed_err), 32'h1);
      chk(32'(safe_out), 32'h7);
    end
    speed_en = 1'b0;
    step(5);
    chk(32'(speed_err), 32'h0);
    speed_en = 1'b1;
    fault = '0;
    step(5);
    chk(32'(speed_err), 32'h0);
    // Chatter shorter than the filter is ignored; a clean level needs the full filter time.
    first_cmd = 3'h0;
    second_cmd = 3'h0;
    step(30);
    bounce = 1'b1;
    first_cmd = 3'h7;
    second_cmd = 3'h7;
    step(40);
    chk(32'(safe_out), 32'h0);
    bounce = 1'b0;
    step(4);
    chk(32'(safe_out), 32'h0);
    step(26);
    chk(32'(safe_out), 32'h7);
    // Manual restart on the solid-state evaluator.
    first_cmd = 3'h0;
    second_cmd = 3'h0;
    step(30);
    setc(2, RST_MANUAL, 1'b0, 8'hff, 1'b0);
    for (int r = 0; r < 2; r++) begin
      first_cmd = 3'h4;
      second_cmd = 3'h4;
      step(30);
      chk(32'(safe_out[2]), 32'h0);
      button_cmd = 3'h4;
      step(30);
      chk(32'(safe_out[2]), 32'h1);
      button_cmd = 3'h0;
      first_cmd = 3'h0;
      second_cmd = 3'h0;
      step(30);
    end
    // Monitored restart needs press and release.
    setc(2, RST_MONITORED, 1'b0, 8'hff, 1'b0);
    first_cmd = 3'h4;
    second_cmd = 3'h4;
    button_cmd = 3'h4;
    step(30);
    chk(32'(safe_out[2]), 32'h0);
    button_cmd = 3'h0;
    step(30);
    chk(32'(safe_out[2]), 32'h1);
    // Skew beyond 2 ms latches an error that blocks the output until idle.
    setc(2, RST_NONE, 1'b0, 8'h02, 1'b0);
    first_cmd = 3'h0;
    second_cmd = 3'h0;
    step(30);
    first_cmd = 3'h4;
    step(40);
    chk(32'(err_out[2]), 32'h1);
    second_cmd = 3'h4;
    step(30);
    chk(32'(safe_out[2]), 32'h0);
    first_cmd = 3'h0;
    second_cmd = 3'h0;
    step(30);
    first_cmd = 3'h4;
    second_cmd = 3'h4;
    step(30);
    chk({30'h0, err_out[2], safe_out[2]}, 32'h1);
    // Power-on test: a second reset with contacts already closed.
    setc(2, RST_NONE, 1'b1, 8'hff, 1'b0);
    rst_n_i = 1'b0;
    step(2);
    rst_n_i = 1'b1;
    step(30);
    chk(32'(safe_out[2]), 32'h0);
    first_cmd = 3'h0;
    second_cmd = 3'h0;
    step(30);
    first_cmd = 3'h4;
    second_cmd = 3'h4;
    step(30);
    chk(32'(safe_out[2]), 32'h1);
    results();
  end
endmodule // testbench
